/* shared/crpm_defines.svh */
// Offsets, field positions, reset values and timing counts of the channel rate and pulse
// measurement block.
// Assumes a 125 MHz front-end clock and APB byte addressing with 32-bit words.
`ifndef CRPM_DEFINES_SVH
`define CRPM_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CRPM_A_CTRL   8'h00
`define CRPM_A_BFIX   8'h04
`define CRPM_A_CHG    8'h08
`define CRPM_A_EDGE   8'h0C
`define CRPM_A_THR    8'h10
`define CRPM_A_GATE   8'h14
`define CRPM_A_HIT    8'h18
`define CRPM_A_TIME   8'h1C
`define CRPM_A_BASE   8'h20
`define CRPM_A_PEAK   8'h24
`define CRPM_A_QSUM   8'h28
`define CRPM_A_EDGES  8'h2C
`define CRPM_A_STAT   8'h30

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define CRPM_B_NEG    0
`define CRPM_B_BFIX   1
`define CRPM_B_AUTOQ  2
`define CRPM_B_FTHR   3
`define CRPM_B_GATE   4
`define CRPM_CTRL_W   5
`define CRPM_CTRL_RST 5'h00

// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define CRPM_SMP_W    12
`define CRPM_IDX_W    10
`define CRPM_DEPTH    1024
`define CRPM_HIT_W    16
`define CRPM_TIME_W   24
`define CRPM_BASE_N   16
`define CRPM_BASE_SH  4
`define CRPM_CFD_SH   4
`define CRPM_CLK_NS   8
`define CRPM_TICK_NS  1000
`define CRPM_TICK_CYC (`CRPM_TICK_NS / `CRPM_CLK_NS)

`endif

/* shared/crpm_pkg.sv */
// Types shared by the channel rate and pulse measurement block.
// Assumes crpm_defines.svh is on the include path.
`include "crpm_defines.svh"

package crpm_pkg;
   typedef logic signed [`CRPM_SMP_W-1:0] crpm_smp_t;
   typedef logic signed [`CRPM_SMP_W:0]   crpm_amp_t;
   typedef logic [`CRPM_IDX_W-1:0]        crpm_idx_t;
   typedef enum logic [1:0] {
      CRPM_IDLE = 2'b00,
      CRPM_CAPT = 2'b01,
      CRPM_SCAN = 2'b10,
      CRPM_FIN  = 2'b11
   } crpm_state_e;
endpackage : crpm_pkg

/* src/crpm_channel.sv */
// One front-end channel: hit rate monitor and pulse measurement from a stored event, APB slave.
// Assumes samples arrive on mclk, at least 16 per event, and the discriminator is async.
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "crpm_defines.svh"

// Function
// - Count discriminator threshold crossings per channel
// - Count elapsed time in 1 MHz ticks
// - Reading the hit counter clears and restarts both
// - Either counter saturated freezes both together
// - Hit and time counts go into event
// - Optional gate blocks hits after a hit
// - Baseline is mean of first 16 samples
// - Reference is computed or fixed user baseline
// - Peak amplitude versus reference, polarity selects direction
// - Peak time is index of peak sample
// - Fixed charge: start cell plus length
// - Auto charge: look back from peak, length
// - Rising and falling edges follow polarity
// - Edge threshold: constant fraction or fixed
// - Constant fraction is 4 bits of sixteenths
// - Fixed edge threshold 12-bit signed versus samples
// - Time over threshold is fall minus rise
// - Hit counter 16 bits, time counter 24
// - Samples are 12-bit two's complement
module crpm_channel (
   input  wire logic                     mclk,
   input  wire logic                     rst,
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic                     disc_in,
   input  wire logic                     smp_valid,
   input  wire logic                     smp_first,
   input  wire logic                     smp_last,
   input  wire crpm_pkg::crpm_smp_t      smp_data,
   output logic                          ev_valid,
   output logic      [`CRPM_HIT_W-1:0]   ev_hit,
   output logic      [`CRPM_TIME_W-1:0]  ev_time,
   output crpm_pkg::crpm_smp_t           ev_base,
   output crpm_pkg::crpm_amp_t           ev_peak,
   output crpm_pkg::crpm_idx_t           ev_peak_time,
   output logic      [23:0]              ev_charge,
   output crpm_pkg::crpm_idx_t           ev_rise,
   output crpm_pkg::crpm_idx_t           ev_fall,
   output crpm_pkg::crpm_idx_t           ev_tot
);
   import crpm_pkg::*;

   // ----------------------------------------------------------------
   // Configuration and APB slave
   // ----------------------------------------------------------------
   logic [`CRPM_CTRL_W-1:0] ctrl_q;
   crpm_smp_t               bfix_q;
   crpm_idx_t               qstart_q;
   crpm_idx_t               qlen_q;
   crpm_idx_t               prech_q;
   logic [3:0]              cfd_q;
   crpm_smp_t               thr_q;
   logic [7:0]              gate_len_q;
   logic [`CRPM_TIME_W-1:0] time_shadow_q;
   logic [`CRPM_HIT_W-1:0]  hit_q;
   logic [`CRPM_TIME_W-1:0] time_q;
   crpm_smp_t               base_q;
   crpm_state_e             state_q;
   logic                    done_q;

   logic setup;
   logic wr_acc;
   logic rd_clr;
   assign setup  = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign rd_clr = psel & penable & ~pwrite & (paddr == `CRPM_A_HIT);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q     <= `CRPM_CTRL_RST;
         bfix_q     <= '0;
         qstart_q   <= '0;
         qlen_q     <= '0;
         prech_q    <= '0;
         cfd_q      <= '0;
         thr_q      <= '0;
         gate_len_q <= '0;
      end else if (wr_acc) begin
         case (paddr)
            `CRPM_A_CTRL: ctrl_q <= pwdata[`CRPM_CTRL_W-1:0];
            `CRPM_A_BFIX: bfix_q <= pwdata[11:0];
            `CRPM_A_CHG: begin
               qstart_q <= pwdata[9:0];
               qlen_q   <= pwdata[25:16];
            end
            `CRPM_A_EDGE: begin
               prech_q <= pwdata[9:0];
               cfd_q   <= pwdata[19:16];
            end
            `CRPM_A_THR:  thr_q <= pwdata[11:0];
            `CRPM_A_GATE: gate_len_q <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read data is fetched in the setup cycle so pready can stay high: zero wait states
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata        <= '0;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         time_shadow_q <= '0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            pslverr <= 1'b0;
            prdata  <= '0;
            case (paddr)
               `CRPM_A_CTRL:  prdata <= {27'h0000000, ctrl_q};
               `CRPM_A_BFIX:  prdata <= {20'h00000, bfix_q};
               `CRPM_A_CHG:   prdata <= {6'h00, qlen_q, 6'h00, qstart_q};
               `CRPM_A_EDGE:  prdata <= {12'h000, cfd_q, 6'h00, prech_q};
               `CRPM_A_THR:   prdata <= {20'h00000, thr_q};
               `CRPM_A_GATE:  prdata <= {24'h000000, gate_len_q};
               `CRPM_A_HIT: begin
                  prdata        <= {16'h0000, hit_q};
                  // Time is snapped with the hit count so the pair stays coherent
                  time_shadow_q <= time_q;
               end
               `CRPM_A_TIME:  prdata <= {8'h00, time_shadow_q};
               `CRPM_A_BASE:  prdata <= {20'h00000, ev_base};
               `CRPM_A_PEAK:  prdata <= {6'h00, ev_peak_time, 3'h0, ev_peak};
               `CRPM_A_QSUM:  prdata <= {8'h00, ev_charge};
               `CRPM_A_EDGES: prdata <= {2'h0, ev_tot, ev_fall, ev_rise};
               `CRPM_A_STAT:  prdata <= {29'h00000000, state_q, done_q};
               default:       pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Hit rate monitor
   // ----------------------------------------------------------------
   logic [1:0] disc_s_q;
   logic       disc_d_q;
   logic [6:0] tdiv_q;
   logic [7:0] gate_q;
   logic       tick;
   logic       hit_edge;
   logic       count_ok;
   logic       frozen;
   logic       cnt_clr;

   assign tick     = (tdiv_q == 7'(`CRPM_TICK_CYC - 1));
   assign hit_edge = disc_s_q[1] & ~disc_d_q;
   assign count_ok = hit_edge & ~(ctrl_q[`CRPM_B_GATE] & (gate_q != 8'h00));
   assign frozen   = (&hit_q) | (&time_q);
   assign cnt_clr  = rd_clr | (state_q == CRPM_FIN);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         disc_s_q <= 2'b00;
         disc_d_q <= 1'b0;
      end else begin
         disc_s_q <= {disc_s_q[0], disc_in};
         disc_d_q <= disc_s_q[1];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tdiv_q <= '0;
      end else if (tick) begin
         tdiv_q <= '0;
      end else begin
         tdiv_q <= tdiv_q + 7'h01;
      end
   end

   // A hit inside the gate neither counts nor re-arms it
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate_q <= '0;
      end else if (count_ok) begin
         gate_q <= gate_len_q;
      end else if (gate_q != 8'h00) begin
         gate_q <= gate_q - 8'h01;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hit_q  <= '0;
         time_q <= '0;
      end else if (cnt_clr) begin
         hit_q  <= '0;
         time_q <= '0;
      end else if (!frozen) begin
         if (count_ok) begin
            hit_q <= hit_q + 16'h0001;
         end
         if (tick) begin
            time_q <= time_q + 24'h000001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture: baseline and peak search while samples stream in
   // ----------------------------------------------------------------
   crpm_idx_t   wr_idx_q;
   crpm_idx_t   last_q;
   logic signed [15:0] sum_q;
   crpm_smp_t   ext_q;
   crpm_idx_t   pk_idx_q;
   logic        neg;
   logic        start_ev;
   logic        wr_en;
   crpm_idx_t   wr_addr;
   logic        better;
   logic signed [15:0] sum_n;

   assign neg      = ctrl_q[`CRPM_B_NEG];
   assign start_ev = (state_q == CRPM_IDLE) & smp_valid & smp_first;
   assign wr_en    = start_ev | ((state_q == CRPM_CAPT) & smp_valid);
   assign wr_addr  = start_ev ? '0 : wr_idx_q;
   assign better   = neg ? (smp_data < ext_q) : (smp_data > ext_q);
   assign sum_n    = (start_ev ? 16'sh0000 : sum_q) + 16'(smp_data);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_idx_q <= '0;
         sum_q    <= '0;
         base_q   <= '0;
         ext_q    <= '0;
         pk_idx_q <= '0;
         last_q   <= '0;
      end else if (wr_en) begin
         wr_idx_q <= wr_addr + 10'h001;
         if (wr_addr < 10'(`CRPM_BASE_N)) begin
            sum_q <= sum_n;
         end
         if (wr_addr == 10'(`CRPM_BASE_N - 1)) begin
            base_q <= 12'(sum_n >>> `CRPM_BASE_SH);
         end
         if (start_ev || better) begin
            ext_q    <= smp_data;
            pk_idx_q <= wr_addr;
         end
         if (smp_last || (wr_addr == 10'(`CRPM_DEPTH - 1))) begin
            last_q <= wr_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // Scan: charge and edges from stored samples
   // ----------------------------------------------------------------
   crpm_idx_t ra_q;
   logic      ra_done_q;
   logic      rv_q;
   crpm_idx_t ri_q;
   crpm_smp_t rdat;
   crpm_smp_t ref_b;
   crpm_amp_t amp;
   crpm_amp_t v;
   crpm_amp_t thr_n;
   logic [16:0] frac;
   crpm_idx_t q_start;
   logic [10:0] q_end;
   logic      in_win;
   logic signed [23:0] chg_q;
   crpm_idx_t rise_q;
   crpm_idx_t fall_q;
   logic      rise_f_q;
   logic      fall_f_q;

   assign ref_b   = ctrl_q[`CRPM_B_BFIX] ? bfix_q : base_q;
   assign amp     = neg ? (13'(ref_b) - 13'(ext_q)) : (13'(ext_q) - 13'(ref_b));
   assign v       = neg ? (13'(ref_b) - 13'(rdat)) : (13'(rdat) - 13'(ref_b));
   assign frac    = 17'(amp) * {13'h0000, cfd_q};
   assign thr_n   = ctrl_q[`CRPM_B_FTHR]
                  ? (neg ? (13'(ref_b) - 13'(thr_q)) : (13'(thr_q) - 13'(ref_b)))
                  : 13'(frac >> `CRPM_CFD_SH);
   assign q_start = ctrl_q[`CRPM_B_AUTOQ]
                  ? ((pk_idx_q >= prech_q) ? (pk_idx_q - prech_q) : '0)
                  : qstart_q;
   assign q_end   = {1'b0, q_start} + {1'b0, qlen_q};
   // Reads never pass last_q, so an oversize window simply ends there
   assign in_win  = (ri_q >= q_start) & ({1'b0, ri_q} < q_end);

   crpm_sample_ram u_ram (
      .mclk  (mclk),
      .rst   (rst),
      .we    (wr_en),
      .waddr (wr_addr),
      .wdata (smp_data),
      .raddr (ra_q),
      .rdata (rdat)
   );

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ra_q      <= '0;
         ra_done_q <= 1'b1;
         rv_q      <= 1'b0;
         ri_q      <= '0;
      end else begin
         rv_q <= (state_q == CRPM_SCAN) & ~ra_done_q;
         ri_q <= ra_q;
         if (state_q != CRPM_SCAN) begin
            ra_q      <= '0;
            ra_done_q <= 1'b0;
         end else if (!ra_done_q) begin
            ra_done_q <= (ra_q == last_q);
            ra_q      <= (ra_q == last_q) ? ra_q : ra_q + 10'h001;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         chg_q    <= '0;
         rise_q   <= '0;
         fall_q   <= '0;
         rise_f_q <= 1'b0;
         fall_f_q <= 1'b0;
      end else if (state_q != CRPM_SCAN) begin
         chg_q    <= '0;
         rise_f_q <= 1'b0;
         fall_f_q <= 1'b0;
      end else if (rv_q) begin
         if (in_win) begin
            chg_q <= chg_q + 24'(v);
         end
         if (!rise_f_q && (ri_q <= pk_idx_q) && (v >= thr_n)) begin
            rise_q   <= ri_q;
            rise_f_q <= 1'b1;
         end
         if (!fall_f_q && (ri_q > pk_idx_q) && (v < thr_n)) begin
            fall_q   <= ri_q;
            fall_f_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sequencer and event output
   // ----------------------------------------------------------------
   crpm_idx_t fall_fin;
   assign fall_fin = fall_f_q ? fall_q : last_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= CRPM_IDLE;
         done_q  <= 1'b0;
      end else begin
         case (state_q)
            CRPM_IDLE: begin
               if (start_ev) begin
                  state_q <= smp_last ? CRPM_SCAN : CRPM_CAPT;
                  done_q  <= 1'b0;
               end
            end
            CRPM_CAPT: begin
               if (smp_valid && (smp_last || (wr_idx_q == 10'(`CRPM_DEPTH - 1)))) begin
                  state_q <= CRPM_SCAN;
               end
            end
            CRPM_SCAN: begin
               if (rv_q && (ri_q == last_q)) begin
                  state_q <= CRPM_FIN;
               end
            end
            CRPM_FIN: begin
               state_q <= CRPM_IDLE;
               done_q  <= 1'b1;
            end
            default: state_q <= CRPM_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ev_valid     <= 1'b0;
         ev_hit       <= '0;
         ev_time      <= '0;
         ev_base      <= '0;
         ev_peak      <= '0;
         ev_peak_time <= '0;
         ev_charge    <= '0;
         ev_rise      <= '0;
         ev_fall      <= '0;
         ev_tot       <= '0;
      end else begin
         ev_valid <= (state_q == CRPM_FIN);
         if (state_q == CRPM_FIN) begin
            ev_hit       <= hit_q;
            ev_time      <= time_q;
            ev_base      <= base_q;
            ev_peak      <= amp;
            ev_peak_time <= pk_idx_q;
            ev_charge    <= chg_q;
            ev_rise      <= rise_q;
            ev_fall      <= fall_fin;
            ev_tot       <= fall_fin - rise_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_read_hit;
      psel && penable && !pwrite && (paddr == `CRPM_A_HIT);
   endsequence

   hit_count_a: assert property (count_ok && !frozen && !cnt_clr |=> hit_q == $past(hit_q) + 16'h0001)
      else $error("hit count did not advance");
   time_tick_a: assert property (tick && !frozen && !cnt_clr |=> time_q == $past(time_q) + 24'h000001)
      else $error("time count did not advance");
   read_clear_a: assert property (s_read_hit |=> (hit_q == 16'h0000) && (time_q == 24'h000000))
      else $error("rate read did not clear counters");
   freeze_pair_a: assert property (frozen && !cnt_clr |=> $stable(hit_q) && $stable(time_q))
      else $error("saturated counters moved");
   event_copy_a: assert property ((state_q == CRPM_FIN) |=> ev_valid && ev_hit == $past(hit_q) ##1 hit_q == 16'h0000 || !frozen)
      else $error("event lacks rate counts");
   gate_block_a: assert property (ctrl_q[`CRPM_B_GATE] && gate_q != 8'h00 && hit_edge && !cnt_clr |=> $stable(hit_q))
      else $error("hit counted inside gate");
   // Level must be the truncated fraction: thr_n less than one count below amp*cfd_q/16
   cfd_level_a: assert property (!ctrl_q[`CRPM_B_FTHR] && !amp[12]
      |-> (int'(thr_n) * 16 <= int'(amp) * int'(cfd_q))
       && (int'(thr_n) * 16 + 16 > int'(amp) * int'(cfd_q)))
      else $error("constant fraction level wrong");
   tot_diff_a: assert property (ev_valid |-> ev_tot == ev_fall - ev_rise)
      else $error("time over threshold mismatch");
endmodule : crpm_channel

`default_nettype wire

/* src/crpm_sample_ram.sv */
// Sample store for one event of one channel, one write and one registered read port.
// Assumes writer and reader never need the same address in the same cycle.
`timescale 1ns/1ns
`default_nettype none
`include "crpm_defines.svh"

module crpm_sample_ram (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               we,
   input  wire crpm_pkg::crpm_idx_t waddr,
   input  wire crpm_pkg::crpm_smp_t wdata,
   input  wire crpm_pkg::crpm_idx_t raddr,
   output var  crpm_pkg::crpm_smp_t rdata
);
   import crpm_pkg::*;

   crpm_smp_t mem [0:`CRPM_DEPTH-1];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule : crpm_sample_ram

`default_nettype wire

/* testbench/crpm_digitizer.sv */
// Sample source model: one 32-sample event per go pulse, flat base plus a 3-sample pulse.
// Assumes the channel takes a sample at each mclk edge where smp_valid is high.
`timescale 1ns/1ns
`default_nettype none
module crpm_digitizer #(
   parameter crpm_pkg::crpm_smp_t BASE = 12'sh0C0
) (
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                go,
   input  wire logic                slow,
   input  wire crpm_pkg::crpm_smp_t amp,
   output logic                     smp_valid,
   output logic                     smp_first,
   output logic                     smp_last,
   output crpm_pkg::crpm_smp_t      smp_data
);
   import crpm_pkg::*;
   // ----
   // Event generator
   // ----
   logic [5:0] k;
   logic       busy;
   logic       ph;
   crpm_smp_t  v;
   // Peak at index 21, half height on each side; sign of amp sets polarity
   always_comb v = BASE + ((k == 6'd21) ? amp : (k == 6'd20 || k == 6'd22) ? (amp >>> 1) : 12'sh000);
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         {busy, ph, k, smp_valid, smp_first, smp_last} <= '0;
         smp_data <= '0;
      end else begin
         ph <= ~ph;
         if (busy && !(slow && ph)) begin
            smp_valid <= 1'b1;
            smp_first <= (k == 6'd0);
            smp_last  <= (k == 6'd31);
            smp_data  <= v;
            k         <= k + 6'd1;
            busy      <= (k != 6'd31);
         end else begin
            // Data line keeps changing when no sample is offered, so stale values never match
            {smp_valid, smp_first, smp_last} <= '0;
            smp_data <= ~smp_data;
            if (!busy) begin
               busy <= go;
               k    <= '0;
            end
         end
      end
   end
endmodule : crpm_digitizer
`default_nettype wire

/* testbench/test_channel_rate_and_pulse_measure.sv */
// Testbench for crpm_channel: APB tasks, rate counter tests and event measurement table.
// Assumes crpm_digitizer as sample source and an APB slave with zero wait states.
`timescale 1ns/1ns
`default_nettype none
`include "crpm_defines.svh"
module test_channel_rate_and_pulse_measure;
   import crpm_pkg::*;
   logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic        disc_in, go, slow, smp_valid, smp_first, smp_last, ev_valid;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] ev_hit;
   logic [23:0] ev_time, ev_charge;
   crpm_smp_t   smp_data, ev_base, amp;
   crpm_amp_t   ev_peak;
   crpm_idx_t   ev_peak_time, ev_rise, ev_fall, ev_tot;
   int          fail_count, n_compared, cyc;
   crpm_channel u_dut (.*);
   crpm_digitizer u_src (.mclk(mclk), .rst(rst), .go(go), .slow(slow), .amp(amp),
      .smp_valid(smp_valid), .smp_first(smp_first), .smp_last(smp_last), .smp_data(smp_data));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ----
   // Tasks
   // ----
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         close_out;
      end
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   // Pulses of p cycles high and p low
   task hits(input int n, input int p);
      repeat (n) begin
         @(posedge mclk);
         disc_in <= 1'b1;
         repeat (p) @(posedge mclk);
         disc_in <= 1'b0;
         repeat (p - 1) @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
   endtask : hits
   task ev(input logic [31:0] c, g, e, input crpm_smp_t h, input logic s,
           input logic [31:0] pk, qs, r, f);
      int i;
      apb(1'b1, `CRPM_A_CTRL, c);
      apb(1'b1, `CRPM_A_CHG, g);
      apb(1'b1, `CRPM_A_EDGE, e);
      @(posedge mclk);
      {amp, slow, go} <= {h, s, 1'b1};
      @(posedge mclk);
      go <= 1'b0;
      for (i = 0; i < 300 && ev_valid !== 1'b1; i++) @(posedge mclk);
      chk(ev_valid, 1);
      chk(ev_base, 32'h0C0);
      chk(ev_peak, pk);
      chk(ev_peak_time, 21);
      chk(ev_charge, qs);
      chk(ev_rise, r);
      chk(ev_fall, f);
      chk(ev_tot, f - r);
      $display("event test done");
   endtask : ev
   // ----
   // Sequence
   // ----
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata, disc_in, go, slow} = '0;
      rst = 1'b1;
      amp = '0;
      {fail_count, n_compared, cyc} = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      apb(1'b0, `CRPM_A_CTRL, 0);
      chk(q, 0);
      apb(1'b0, 8'h40, 0);
      chk(err, 1);
      chk(q, 0);
      apb(1'b1, `CRPM_A_BFIX, 32'h0C4);
      apb(1'b1, `CRPM_A_THR, 32'h0E8);
      apb(1'b0, `CRPM_A_BFIX, 0);
      chk(q, 32'h0C4);
      $display("register test done");
      apb(1'b0, `CRPM_A_HIT, 0);
      hits(5, 4);
      apb(1'b0, `CRPM_A_HIT, 0);
      chk(q, 5);
      apb(1'b0, `CRPM_A_HIT, 0);
      chk(q, 0);
      repeat (400) @(posedge mclk);
      apb(1'b0, `CRPM_A_HIT, 0);
      apb(1'b0, `CRPM_A_TIME, 0);
      chk(q >= 3 && q <= 4, 1);
      apb(1'b1, `CRPM_A_GATE, 20);
      apb(1'b1, `CRPM_A_CTRL, 32'h10);
      apb(1'b0, `CRPM_A_HIT, 0);
      hits(5, 4);
      apb(1'b0, `CRPM_A_HIT, 0);
      chk(q, 2);
      apb(1'b1, `CRPM_A_CTRL, 0);
      apb(1'b0, `CRPM_A_HIT, 0);
      hits(3, 4);
      $display("rate test done");
      ev(0, 32'h0003_0014, 32'h0008_0000, 12'sh040, 1'b0, 64, 128, 20, 23);
      chk(ev_hit, 3);
      // Under one 1 us tick passes between the clearing read and the event end
      chk(ev_time <= 1, 1);
      ev(1, 32'h0003_0014, 32'h000F_0000, -12'sh040, 1'b1, 64, 128, 21, 22);
      ev(4, 32'h0002_0000, 32'h0008_0002, 12'sh040, 1'b0, 64, 32, 20, 23);
      ev(2, 32'h0064_0015, 32'h0008_0000, 12'sh040, 1'b1, 60, 52, 21, 22);
      ev(8, 32'h0003_0014, 32'h0008_0000, 12'sh040, 1'b0, 64, 128, 21, 22);
      apb(1'b0, `CRPM_A_QSUM, 0);
      chk(q, 128);
      close_out;
   end
endmodule : test_channel_rate_and_pulse_measure
`default_nettype wire
